/* verilog/dacsc_pkg.sv */
// dacsc_pkg: constants and types for the dac serial control register bank.
// assumes the serial control word is 7-bit address plus 9-bit data, msb first.
package dacsc_pkg;

    // ------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS   = 16;
    localparam int ADDR_MSB    = 15;
    localparam int ADDR_LSB    = 9;
    localparam int DATA_MSB    = 8;
    localparam int DATA_LSB    = 0;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] CHANNEL_ROUTING_CONTROL = 7'h02;
    localparam logic [6:0] AUDIO_FORMAT_CONTROL    = 7'h03;
    localparam logic [6:0] VOLUME_UPDATE_CONTROL   = 7'h09;
    localparam logic [6:0] FOURTH_PAIR_CONTROL     = 7'h0f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ATTEN_LINK_BIT  = 3;
    localparam int ROUTE_LSB       = 5;
    localparam int FMT_LSB         = 0;
    localparam int FCP_BIT         = 2;
    localparam int BCP_BIT         = 3;
    localparam int WL_LSB          = 4;
    localparam int INV_LSB         = 6;
    localparam int INV4_BIT        = 3;
    localparam int ZC_BIT          = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] ROUTE_RESET = 4'h9;
    localparam logic [1:0] FMT_RESET   = 2'h0;
    localparam logic [1:0] WL_RESET    = 2'h0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FMT_RJ  = 2'h0;
    localparam logic [1:0] FMT_LJ  = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] WL_16   = 2'h0;
    localparam logic [1:0] WL_20   = 2'h1;
    localparam logic [1:0] WL_24   = 2'h2;
    localparam logic [1:0] WL_32   = 2'h3;
    localparam logic [1:0] ROUTE_MUTE = 2'h0;
    localparam logic [1:0] ROUTE_LEFT = 2'h1;
    localparam logic [1:0] ROUTE_RIGHT = 2'h2;
    localparam logic [1:0] ROUTE_AVG  = 2'h3;

    // hardware-mode pin decode (latch pin, clock pin)
    localparam logic [1:0] HW_RJ24  = 2'h0;
    localparam logic [1:0] HW_RJ20  = 2'h1;
    localparam logic [1:0] HW_I2S16 = 2'h2;

    // soft-mute time constant in input samples, and i2s auto-detect frame
    localparam int MUTE_TC_SAMPLES  = 64;
    localparam int AUTO16_FRAME_BCK = 32;
    localparam int AUTO16_HALF_BCK  = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] format_select;
        logic       frame_clock_polarity;
        logic       bit_clock_polarity;
        logic [1:0] word_length_select;
        logic       dsp_variant_b;
        logic       bit_clock_falling;
        logic [1:0] active_word_length;
    } dacsc_fmt_t;

    typedef struct packed {
        logic [1:0] left_route;
        logic [1:0] right_route;
        logic       right_uses_left_atten;
        logic [3:0] pair_invert;
        logic       zero_cross_select;
        logic       zero_cross_enable;
    } dacsc_out_t;

endpackage

/* verilog/dacsc_regs.sv */
// dacsc_regs: three-wire serial control port and configuration register bank.
// assumes the serial pins are asynchronous to sys_clk; the shifter runs on the
// serial clock pin as its own domain, words cross to sys_clk by a toggle.
`timescale 1ns/1ps
`default_nettype none

module dacsc_regs
    import dacsc_pkg::*;
(
    // system
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // serial control pins
    input  wire logic        serial_clock_pin,
    input  wire logic        serial_data_pin,
    input  wire logic        serial_latch_pin,
    input  wire logic        control_mode_pin,
    // audio path hooks
    input  wire logic        i2s_frame_is_32,
    input  wire logic        analogue_mute_req,
    // configuration out
    output dacsc_fmt_t       fmt_cfg,
    output dacsc_out_t       out_cfg,
    output logic             hardware_mode,
    output logic             deemphasis_on,
    output logic             analogue_mute_en,
    output logic             write_strobe
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    wire        rst_n = rst_sync_q[1];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) rst_sync_q <= 2'h0;
        else       rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // ------------------------------------------------------------
    // serial clock domain: shifter
    // ------------------------------------------------------------
    // the shift register only sees edges while the host clocks; the word is
    // held until the latch edge, so no edge after the frame is needed here.
    logic [WORD_BITS-1:0] shift_q;

    always_ff @(posedge serial_clock_pin) begin
        shift_q <= {shift_q[WORD_BITS-2:0], serial_data_pin};
    end

    // latch edge: capture word and toggle, on the latch pin's own edge
    logic [WORD_BITS-1:0] word_q;
    logic                 word_tgl_q;

    always_ff @(posedge serial_latch_pin or negedge nrst) begin
        if (!nrst) begin
            word_tgl_q <= 1'b0;
        end else begin
            word_tgl_q <= ~word_tgl_q;
        end
    end

    always_ff @(posedge serial_latch_pin) begin
        word_q <= shift_q;
    end

    // ------------------------------------------------------------
    // crossing into sys_clk
    // ------------------------------------------------------------
    // word_q is stable for many sys_clk cycles after the toggle, since the
    // host cannot shift a new word faster than the synchroniser settles.
    logic [2:0] tgl_sync_q;
    logic [1:0] mode_sync_q;
    logic [1:0] ck_sync_q;
    logic [1:0] dt_sync_q;
    logic [1:0] lt_sync_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_sync_q  <= 3'h0;
            mode_sync_q <= 2'h0;
            ck_sync_q   <= 2'h0;
            dt_sync_q   <= 2'h0;
            lt_sync_q   <= 2'h0;
        end else begin
            tgl_sync_q  <= {tgl_sync_q[1:0], word_tgl_q};
            mode_sync_q <= {mode_sync_q[0], control_mode_pin};
            ck_sync_q   <= {ck_sync_q[0], serial_clock_pin};
            dt_sync_q   <= {dt_sync_q[0], serial_data_pin};
            lt_sync_q   <= {lt_sync_q[0], serial_latch_pin};
        end
    end

    wire       hw_mode   = mode_sync_q[1];
    wire       word_new  = tgl_sync_q[2] ^ tgl_sync_q[1];
    wire       sw_write  = word_new & ~hw_mode;
    wire [6:0] wr_addr   = word_q[ADDR_MSB:ADDR_LSB];
    wire [8:0] wr_data   = word_q[DATA_MSB:DATA_LSB];

    wire we_route = sw_write && (wr_addr == CHANNEL_ROUTING_CONTROL);
    wire we_fmt   = sw_write && (wr_addr == AUDIO_FORMAT_CONTROL);
    wire we_vol   = sw_write && (wr_addr == VOLUME_UPDATE_CONTROL);
    wire we_pair4 = sw_write && (wr_addr == FOURTH_PAIR_CONTROL);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic       link_q;
    logic [3:0] route_q;
    logic [1:0] fmt_q;
    logic       fcp_q;
    logic       bcp_q;
    logic [1:0] wl_q;
    logic [2:0] inv_q;
    logic       inv4_q;
    logic       zc_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_q  <= 1'b0;
            route_q <= ROUTE_RESET;
        end else if (we_route) begin
            link_q  <= wr_data[ATTEN_LINK_BIT];
            route_q <= wr_data[ROUTE_LSB +: 4];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fmt_q <= FMT_RESET;
            fcp_q <= 1'b0;
            bcp_q <= 1'b0;
            wl_q  <= WL_RESET;
            inv_q <= 3'h0;
        end else if (we_fmt) begin
            fmt_q <= wr_data[FMT_LSB +: 2];
            fcp_q <= wr_data[FCP_BIT];
            bcp_q <= wr_data[BCP_BIT];
            wl_q  <= wr_data[WL_LSB +: 2];
            inv_q <= wr_data[INV_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)      zc_q <= 1'b0;
        else if (we_vol) zc_q <= wr_data[ZC_BIT];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)        inv4_q <= 1'b0;
        else if (we_pair4) inv4_q <= wr_data[INV4_BIT];
    end

    // ------------------------------------------------------------
    // effective configuration
    // ------------------------------------------------------------
    // in hardware mode the serial pins are static straps: latch picks i2s,
    // latch and clock together pick word length, data picks de-emphasis.
    wire [1:0] hw_sel = {lt_sync_q[1], ck_sync_q[1]};

    function automatic logic [1:0] hw_fmt(input logic [1:0] sel);
        hw_fmt = (sel == HW_RJ24 || sel == HW_RJ20) ? FMT_RJ : FMT_I2S;
    endfunction

    function automatic logic [1:0] hw_wl(input logic [1:0] sel);
        unique case (sel)
            HW_RJ24:  hw_wl = WL_24;
            HW_RJ20:  hw_wl = WL_20;
            HW_I2S16: hw_wl = WL_16;
            default:  hw_wl = WL_24;
        endcase
    endfunction

    wire [1:0] eff_fmt = hw_mode ? hw_fmt(hw_sel) : fmt_q;
    wire [1:0] eff_wl  = hw_mode ? hw_wl(hw_sel)  : wl_q;
    wire       eff_fcp = hw_mode ? 1'b0 : fcp_q;
    wire       eff_bcp = hw_mode ? 1'b0 : bcp_q;

    // rj cannot carry 32 bits; i2s24 frame of 32 clocks drops to 16
    wire [1:0] wl_rj   = (eff_fmt == FMT_RJ && eff_wl == WL_32) ? WL_24 : eff_wl;
    wire       auto16  = (eff_fmt == FMT_I2S) && (eff_wl == WL_24) && i2s_frame_is_32;
    wire [1:0] act_wl  = auto16 ? WL_16 : wl_rj;

    dacsc_fmt_t fmt_d;
    dacsc_out_t out_d;

    always_comb begin
        fmt_d.format_select        = eff_fmt;
        fmt_d.frame_clock_polarity = (eff_fmt != FMT_DSP) & eff_fcp;
        fmt_d.dsp_variant_b        = (eff_fmt == FMT_DSP) & eff_fcp;
        fmt_d.bit_clock_polarity   = eff_bcp;
        fmt_d.bit_clock_falling    = eff_bcp;
        fmt_d.word_length_select   = eff_wl;
        fmt_d.active_word_length   = act_wl;
        out_d.left_route           = hw_mode ? ROUTE_LEFT  : route_q[1:0];
        out_d.right_route          = hw_mode ? ROUTE_RIGHT : route_q[3:2];
        out_d.right_uses_left_atten = ~hw_mode & link_q;
        out_d.pair_invert          = hw_mode ? 4'h0 : {inv4_q, inv_q};
        out_d.zero_cross_select    = zc_q;
        out_d.zero_cross_enable    = ~zc_q;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fmt_cfg          <= '0;
            out_cfg          <= '0;
            hardware_mode    <= 1'b0;
            deemphasis_on    <= 1'b0;
            analogue_mute_en <= 1'b0;
            write_strobe     <= 1'b0;
        end else begin
            fmt_cfg          <= fmt_d;
            out_cfg          <= out_d;
            hardware_mode    <= hw_mode;
            deemphasis_on    <= hw_mode & dt_sync_q[1];
            analogue_mute_en <= ~hw_mode & analogue_mute_req;
            write_strobe     <= sw_write;
        end
    end

endmodule

`default_nettype wire

/* dv/dacsc_properties.sv */
// dacsc_chk: port-level assertions for dacsc_regs.
// assumes it sees only top ports; bound to the design below.
`timescale 1ns/1ps
`default_nettype none
module dacsc_chk
    import dacsc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       control_mode_pin,
    input wire logic       i2s_frame_is_32,
    input wire dacsc_fmt_t fmt_cfg,
    input wire dacsc_out_t out_cfg,
    input wire logic       hardware_mode,
    input wire logic       analogue_mute_en,
    input wire logic       write_strobe
);
    // cycles of steady software mode; outputs lag reset and mode pin
    logic [3:0] up_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            up_q <= 4'h0;
        end else if (control_mode_pin) begin
            up_q <= 4'h0;
        end else if (up_q != 4'hf) begin
            up_q <= up_q + 4'h1;
        end
    end
    wire logic sw_ok = (up_q == 4'hf);
    wire logic hw_ok = hardware_mode;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_strobe_pulse: assert property (write_strobe |=> !write_strobe)
        else $error("strobe longer than one cycle");
    // config output flop lags the strobe by one cycle, so the change shows after it
    a_cfg_hold: assert property (sw_ok && !$past(write_strobe) |-> $stable(out_cfg))
        else $error("output config moved without a write");
    a_hw_drop: assert property (hw_ok && $past(hw_ok) |-> !write_strobe)
        else $error("write accepted in hardware mode");
    a_hw_route: assert property (hw_ok && $past(hw_ok, 3) |-> out_cfg.left_route == ROUTE_LEFT
        && out_cfg.right_route == ROUTE_RIGHT && out_cfg.pair_invert == 4'h0)
        else $error("hardware mode routing not forced");
    a_amute_hw: assert property (hw_ok && $past(hw_ok, 3) |-> !analogue_mute_en)
        else $error("analogue mute in hardware mode");
    a_zc_inverse: assert property (sw_ok |-> out_cfg.zero_cross_enable
        != out_cfg.zero_cross_select)
        else $error("zero cross enable not inverse of bit");
    a_bcp_edge: assert property (sw_ok |-> fmt_cfg.bit_clock_falling
        == fmt_cfg.bit_clock_polarity)
        else $error("bit clock edge mismatch");
    a_dsp_variant: assert property (sw_ok && fmt_cfg.format_select == FMT_DSP
        |-> !fmt_cfg.frame_clock_polarity)
        else $error("frame polarity active in dsp");
    a_rj32_as24: assert property (sw_ok && fmt_cfg.format_select == FMT_RJ
        && fmt_cfg.word_length_select == WL_32 |-> fmt_cfg.active_word_length == WL_24)
        else $error("rj 32 not run as 24");
    a_auto_sixteen: assert property (sw_ok && fmt_cfg.format_select == FMT_I2S
        && fmt_cfg.word_length_select == WL_24 && i2s_frame_is_32 && $past(i2s_frame_is_32)
        && $past(i2s_frame_is_32, 2) |-> fmt_cfg.active_word_length == WL_16)
        else $error("32 clock frame not run as 16");
    c_write: cover property (write_strobe);
    c_hw: cover property (hw_ok && $past(hw_ok, 3));
    c_auto: cover property (sw_ok && fmt_cfg.format_select == FMT_I2S && i2s_frame_is_32);
endmodule
bind dacsc_regs dacsc_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .control_mode_pin(control_mode_pin), .i2s_frame_is_32(i2s_frame_is_32),
    .fmt_cfg(fmt_cfg), .out_cfg(out_cfg), .hardware_mode(hardware_mode),
    .analogue_mute_en(analogue_mute_en), .write_strobe(write_strobe));
`default_nettype wire

/* dv/dacsc_host.sv */
// dacsc_host: host model shifting control words into the serial pins.
// assumes a free 15 ns link clock; the serial clock only runs in frames.
`timescale 1ns/1ps
`default_nettype none
module dacsc_host (
    input  wire logic lclk,
    output logic      serial_clock_pin,
    output logic      serial_data_pin,
    output logic      serial_latch_pin
);
    logic run    = 1'b0;
    logic cstrap = 1'b0;
    assign serial_clock_pin = (lclk & run) | cstrap;
    initial begin
        serial_data_pin  = 1'b0;
        serial_latch_pin = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(negedge lclk);
            serial_data_pin = w[i];
            run = 1'b1;
        end
        @(negedge lclk);
        run = 1'b0;
        // released line shows the inverse, never a stale bit
        serial_data_pin = ~serial_data_pin;
        @(negedge lclk);
        serial_latch_pin = 1'b1;
        @(negedge lclk);
        serial_latch_pin = 1'b0;
    endtask
    task automatic strap(input logic l, input logic c, input logic d);
        serial_latch_pin <= l;
        cstrap           <= c;
        serial_data_pin  <= d;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// tb_top: self-checking bench for dacsc_regs.
// assumes the host model owns the serial pins; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dacsc_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        lclk = 1'b0;
    logic        nrst;
    logic        control_mode_pin = 1'b0;
    logic        i2s_frame_is_32 = 1'b0;
    logic        analogue_mute_req = 1'b0;
    wire logic   sck, sdi, slat;
    dacsc_fmt_t  fmt_cfg;
    dacsc_out_t  out_cfg;
    logic        hardware_mode, deemphasis_on, analogue_mute_en, write_strobe;
    int          fails = 0;
    int          check_count = 0;
    logic [15:0] rnd = 16'h0020;
    logic [8:0]  r2 = 9'h120, r3 = 9'h000, r9 = 9'h000, rf = 9'h000;
    always #2 sys_clk = ~sys_clk;
    always #7.5 lclk = ~lclk;
    dacsc_regs dut (.sys_clk(sys_clk), .nrst(nrst), .serial_clock_pin(sck),
        .serial_data_pin(sdi), .serial_latch_pin(slat), .control_mode_pin(control_mode_pin),
        .i2s_frame_is_32(i2s_frame_is_32), .analogue_mute_req(analogue_mute_req),
        .fmt_cfg(fmt_cfg), .out_cfg(out_cfg), .hardware_mode(hardware_mode),
        .deemphasis_on(deemphasis_on), .analogue_mute_en(analogue_mute_en),
        .write_strobe(write_strobe));
    dacsc_host host (.lclk(lclk), .serial_clock_pin(sck), .serial_data_pin(sdi),
        .serial_latch_pin(slat));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [1:0] act_wl(input logic [8:0] f, input logic p32);
        if (f[1:0] == FMT_RJ && f[5:4] == WL_32) return WL_24;
        if (f[1:0] == FMT_I2S && f[5:4] == WL_24 && p32) return WL_16;
        return f[5:4];
    endfunction
    // strap pair {latch, clock} to {format, word length}
    function automatic logic [3:0] hw_exp(input int s);
        case (s[1:0])
            2'h0:    return {FMT_RJ, WL_24};
            2'h1:    return {FMT_RJ, WL_20};
            2'h2:    return {FMT_I2S, WL_16};
            default: return {FMT_I2S, WL_24};
        endcase
    endfunction
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (!ok) begin
            fails++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic expect_sw();
        dacsc_fmt_t f;
        dacsc_out_t o;
        f = '{r3[1:0], (r3[1:0] == FMT_DSP) ? 1'b0 : r3[2], r3[3], r3[5:4],
              (r3[1:0] == FMT_DSP) & r3[2], r3[3], act_wl(r3, i2s_frame_is_32)};
        o = '{r2[6:5], r2[8:7], r2[3], {rf[3], r3[8:6]}, r9[0], ~r9[0]};
        chk(fmt_cfg === f, "format config");
        chk(out_cfg === o, "output config");
        chk(analogue_mute_en === analogue_mute_req, "analogue mute");
        chk(hardware_mode === 1'b0 && deemphasis_on === 1'b0, "software mode");
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        int n;
        n = 0;
        // the strobe can come and go before the host has dropped the latch
        fork
            host.send({a, d});
            begin
                @(negedge sys_clk);
                while (write_strobe !== 1'b1 && n < 200) begin
                    @(negedge sys_clk);
                    n++;
                end
                // config outputs land one cycle behind the strobe
                @(negedge sys_clk);
            end
        join
        chk(n < 200, "no write strobe");
        case (a)
            CHANNEL_ROUTING_CONTROL: r2 = d;
            AUDIO_FORMAT_CONTROL:    r3 = d;
            VOLUME_UPDATE_CONTROL:   r9 = d;
            FOURTH_PAIR_CONTROL:     rf = d;
            default: ;
        endcase
        expect_sw();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        static logic [6:0] adr [5] = '{CHANNEL_ROUTING_CONTROL, AUDIO_FORMAT_CONTROL,
            VOLUME_UPDATE_CONTROL, FOURTH_PAIR_CONTROL, 7'h05};
        static logic [8:0] cor [4] = '{9'h030, 9'h022, 9'h007, 9'h1ff};
        // a real falling edge, so the latch-domain toggle leaves unknown
        nrst <= 1'b0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        expect_sw();
        foreach (cor[i]) begin
            @(posedge sys_clk);
            i2s_frame_is_32 <= 1'b1;
            wr(AUDIO_FORMAT_CONTROL, cor[i]);
        end
        for (int i = 0; i < 25; i++) begin
            @(posedge sys_clk);
            rnd = lfsr(rnd);
            i2s_frame_is_32 <= rnd[0];
            analogue_mute_req <= rnd[1];
            wr(adr[i % 5], rnd[15:7]);
        end
        @(posedge sys_clk);
        control_mode_pin <= 1'b1;
        analogue_mute_req <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            host.strap(s[1], s[0], s[0]);
            repeat (8) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({fmt_cfg.format_select, fmt_cfg.word_length_select} === hw_exp(s),
                "strap decode");
            chk(deemphasis_on === s[0], "deemphasis strap");
        end
        host.strap(1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        host.send({AUDIO_FORMAT_CONTROL, 9'h1ff});
        @(posedge sys_clk);
        host.strap(1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(hardware_mode === 1'b1 && deemphasis_on === 1'b1, "hardware mode");
        chk(fmt_cfg.format_select === FMT_I2S && fmt_cfg.word_length_select === WL_16,
            "strap decode");
        chk(out_cfg.left_route === ROUTE_LEFT && analogue_mute_en === 1'b0, "hw forced");
        // back to software: the word sent in hardware mode must not have landed
        host.strap(1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        control_mode_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        expect_sw();
        // reset in mid-run restores the reset values, then a write still lands
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        r2 = 9'h120;
        r3 = 9'h000;
        r9 = 9'h000;
        rf = 9'h000;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        expect_sw();
        @(posedge sys_clk);
        wr(AUDIO_FORMAT_CONTROL, 9'h0a1);
        complete_run();
    end
endmodule
`default_nettype wire
